// File: design/sbc_standby.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// standby controller: halt, stop wake, settle
// ----------------------------------------
module sbc_standby import sbc_pkg::*; #(
    parameter int SETTLE_CYC = SBC_SETTLE_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic hw_reset_req,
    input wire logic pin_or_por_reset,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_byte,
    input wire logic [2:0] reg_bit,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic halt_exec,
    input wire logic stop_exec,
    input wire logic crystal_osc_stop,
    input wire logic crystal_clock,
    input wire logic crystal_osc_pin,
    input wire logic cpu_on_crystal,
    input wire logic ext_clock_mode,
    input wire logic irq_pending,
    input wire logic irq_mask_flag,
    input wire logic irq_priority_flag,
    input wire logic irq_accept_enable,
    input wire logic in_service_priority,
    input wire logic wdt_osc_stoppable,
    input wire logic main_stop_req,
    output logic cpu_clk_en,
    output logic cpu_reset,
    output logic vector_take,
    output logic resume_next,
    output logic main_clk_keep,
    output logic wdt_clk_en,
    output logic halted
);
    sbc_state_t st_r, st_nxt;
    logic [2:0] sel_r, sel_nxt;
    logic vec_r, vec_nxt;
    logic vec_out_r, vec_out_nxt;
    logic next_out_r, next_out_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rst_seen_r, rst_seen_nxt;
    logic [SBC_FLAGS-1:0] flags;
    logic cnt_done, cnt_clear, wake_busy, settle_busy, wake_load, settle_load;
    logic unmasked, take_vector;
    logic [SBC_WAKE_W-1:0] wake_cnt;
    logic [22:0] settle_cnt;
    logic [16:0] limit;
    logic [7:0] status_byte;

    // ----------------------------------------
    // release decision
    // ----------------------------------------
    assign unmasked = irq_pending && !irq_mask_flag;
    // priority 0 is high; low vectors only when no high service runs
    assign take_vector = irq_accept_enable && (!irq_priority_flag || in_service_priority);
    assign wake_cnt = take_vector ? SBC_WAKE_W'(SBC_WAKE_VEC) : SBC_WAKE_W'(SBC_WAKE_NEXT);
    assign limit = sbc_sel_limit(sel_r);
    // flag bits read msb-first: bit 4 is the shortest time
    assign status_byte = {3'h0, flags[0], flags[1], flags[2], flags[3], flags[4]};
    assign cnt_clear = rst_seen_r || stop_exec || crystal_osc_stop;

    sbc_settle_cnt u_cnt (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .crystal_clock(crystal_clock),
        .osc_running(crystal_osc_pin && !crystal_osc_stop),
        .clear(cnt_clear),
        .limit(limit),
        .flags(flags),
        .done(cnt_done)
    );

    sbc_wake_timer #(.W(SBC_WAKE_W)) u_wake (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .load(wake_load),
        .count(wake_cnt),
        .busy(wake_busy)
    );

    // voltage settling wait after pin or power-on reset
    sbc_wake_timer #(.W(23)) u_settle (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .load(settle_load),
        .count(settle_cnt),
        .busy(settle_busy)
    );
    assign settle_cnt = 23'(SETTLE_CYC);

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        st_nxt = st_r;
        vec_nxt = vec_r;
        wake_load = 1'b0;
        settle_load = 1'b0;
        vec_out_nxt = 1'b0;
        next_out_nxt = 1'b0;
        rst_seen_nxt = 1'b0;
        if (hw_reset_req) begin
            // reset ends any standby state like a normal reset
            st_nxt = SBC_SETTLE;
            settle_load = pin_or_por_reset;
            rst_seen_nxt = 1'b1;
        end else begin
            case (st_r)
                SBC_RUN: begin
                    if (halt_exec) begin
                        st_nxt = SBC_HALT;
                    end else if (stop_exec) begin
                        st_nxt = SBC_STOP;
                    end
                end
                SBC_HALT: begin
                    if (unmasked) begin
                        st_nxt = SBC_WAKE;
                        vec_nxt = take_vector;
                        wake_load = 1'b1;
                    end
                end
                SBC_STOP: begin
                    // crystal cpu waits out the selected time before the wake wait
                    if (unmasked && (!cpu_on_crystal || ext_clock_mode || cnt_done)) begin
                        st_nxt = SBC_WAKE;
                        vec_nxt = take_vector;
                        wake_load = 1'b1;
                    end
                end
                SBC_WAKE: begin
                    if (!wake_busy) begin
                        st_nxt = SBC_RUN;
                        vec_out_nxt = vec_r;
                        next_out_nxt = !vec_r;
                    end
                end
                SBC_SETTLE: begin
                    // external clock needs no oscillation wait, only voltage settle
                    if (!settle_busy && (ext_clock_mode || !cpu_on_crystal || cnt_done)) begin
                        st_nxt = SBC_RUN;
                    end
                end
                default: st_nxt = SBC_SETTLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r <= SBC_SETTLE;
            vec_r <= 1'b0;
            vec_out_r <= 1'b0;
            next_out_r <= 1'b0;
            rst_seen_r <= 1'b1;
        end else begin
            st_r <= st_nxt;
            vec_r <= vec_nxt;
            vec_out_r <= vec_out_nxt;
            next_out_r <= next_out_nxt;
            rst_seen_r <= rst_seen_nxt;
        end
    end

    // ----------------------------------------
    // register port
    // ----------------------------------------
    // select takes only byte writes; status ignores writes
    always_comb begin
        sel_nxt = sel_r;
        rdata_nxt = 8'h00;
        if (reg_wr && reg_byte && reg_addr == SBC_ADDR_SELECT) begin
            sel_nxt = reg_wdata[2:0];
        end
        if (reg_rd) begin
            if (reg_addr == SBC_ADDR_STATUS) begin
                // bit reads return only the chosen bit in place
                rdata_nxt = reg_byte ? status_byte : (status_byte & (8'h01 << reg_bit));
            end else if (reg_addr == SBC_ADDR_SELECT) begin
                rdata_nxt = reg_byte ? {5'h00, sel_r} : ({5'h00, sel_r} & (8'h01 << reg_bit));
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sel_r <= SBC_SELECT_RST;
            rdata_r <= SBC_STATUS_RST;
        end else begin
            sel_r <= (hw_reset_req ? SBC_SELECT_RST : sel_nxt);
            rdata_r <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata = rdata_r;
    assign halted = (st_r == SBC_HALT);
    assign cpu_clk_en = (st_r == SBC_RUN);
    assign cpu_reset = (st_r == SBC_SETTLE);
    assign vector_take = vec_out_r;
    assign resume_next = next_out_r;
    // active main clock is pinned on in halt; a stop request cannot win
    assign main_clk_keep = (st_r == SBC_HALT) || (!main_stop_req);
    assign wdt_clk_en = !((st_r == SBC_HALT || st_r == SBC_STOP) && wdt_osc_stoppable);

    halt_clock_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_r == SBC_HALT) |-> !cpu_clk_en) else $error("cpu clock on in halt");
    masked_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_r == SBC_HALT && !hw_reset_req && (!irq_pending || irq_mask_flag)) |=> (st_r == SBC_HALT))
        else $error("masked request left halt");
    halt_release_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_r == SBC_HALT && unmasked && !hw_reset_req) |=> (st_r == SBC_WAKE)) else $error("no release");
    vec_wake_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst || hw_reset_req)
        (st_r == SBC_HALT && unmasked && take_vector) |-> ##12 (st_r == SBC_WAKE) ##1 vector_take)
        else $error("vector wake length wrong");
    next_wake_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (st_r == SBC_HALT && unmasked && !take_vector && !hw_reset_req) ##1 (!hw_reset_req)[*4]
        |=> (st_r == SBC_WAKE) ##1 resume_next) else $error("next wake length wrong");
    reset_ends_halt_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        hw_reset_req |=> cpu_reset && sel_r == SBC_SELECT_RST) else $error("reset not taken");
    status_top_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        reg_rd |=> reg_rdata[7:5] == 3'h0) else $error("status top bits set");
    halt_main_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        halted |-> main_clk_keep) else $error("main clock dropped in halt");
    stop_clears_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        stop_exec |=> flags == '0) else $error("status not cleared");
endmodule : sbc_standby
`default_nettype wire

// File: inc/sbc_pkg.sv
// Functional notes
// - status register clears on reset release, stop instruction, or crystal stop bit set
// - status register readable by bit or byte; writes are ignored
// - status bits set in order from bit 4 at 2^11..2^16 cycles; top bits zero
// - after stop release counting ends at the selected time; longer flags stay zero
// - reset loads wait-select register with 05h, the longest wait
// - select codes 1..5 give 2^11,2^13,2^14,2^15,2^16; others prohibited; bits 7..3 zero
// - wait-select register is written only by whole-byte accesses
// - with crystal clock as cpu clock, cpu held after stop until wait elapses
// - counting starts only once crystal oscillation has started
// - halt instruction enters halt whatever main clock drives the cpu
// - in halt the cpu clock is gated off; other oscillators keep their state
// - in halt the active main clock keeps running; stop attempts are ignored
// - in halt peripherals stay operable; watchdog clock stops if option allows
// - unmasked request ends halt; vector if acknowledge enabled, else next instruction
// - wake wait 11 or 12 clocks before vectoring, 4 or 5 otherwise
// - masked request keeps halt; vector on high priority, or low with no high service
// - reset ends halt and proceeds as normal reset from the reset vector
// - pin or power-on reset waits 1.61 to 5.27 ms for voltage settling
// - no stabilization wait after reset when an external clock is used
// - priority flag 0 is high priority, 1 is low priority
package sbc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [15:0] SBC_ADDR_STATUS = 16'hffa3;
    localparam logic [15:0] SBC_ADDR_SELECT = 16'hffa4;
    localparam logic [7:0] SBC_STATUS_RST = 8'h00;
    localparam logic [2:0] SBC_SELECT_RST = 3'h5;
    localparam int SBC_FLAGS = 5;
    localparam int SBC_CNT_W = 17;
    // select codes
    localparam logic [2:0] SBC_SEL_2P11 = 3'h1;
    localparam logic [2:0] SBC_SEL_2P16 = 3'h5;
    // crystal cycle thresholds, indexed by flag (0 = shortest)
    localparam logic [16:0] SBC_T_2P11 = 17'h00800;
    localparam logic [16:0] SBC_T_2P13 = 17'h02000;
    localparam logic [16:0] SBC_T_2P14 = 17'h04000;
    localparam logic [16:0] SBC_T_2P15 = 17'h08000;
    localparam logic [16:0] SBC_T_2P16 = 17'h10000;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int SBC_CLK_KHZ = 20000;
    localparam int SBC_SETTLE_US = 1610; // least voltage settling, 1.61 ms
    localparam int SBC_SETTLE_CYC = (SBC_SETTLE_US * SBC_CLK_KHZ + 999) / 1000;
    localparam int SBC_WAKE_VEC = 11;
    localparam int SBC_WAKE_NEXT = 4;
    localparam int SBC_WAKE_W = 4;

    typedef enum logic [4:0] {
        SBC_RUN = 5'h01,
        SBC_HALT = 5'h02,
        SBC_WAKE = 5'h04,
        SBC_STOP = 5'h08,
        SBC_SETTLE = 5'h10
    } sbc_state_t;

    // flag threshold lookup, shared by counter and select decode
    function automatic logic [16:0] sbc_thresh(input int idx);
        case (idx)
            0: sbc_thresh = SBC_T_2P11;
            1: sbc_thresh = SBC_T_2P13;
            2: sbc_thresh = SBC_T_2P14;
            3: sbc_thresh = SBC_T_2P15;
            default: sbc_thresh = SBC_T_2P16;
        endcase
    endfunction : sbc_thresh

    // selected wait length; prohibited codes fall back to the longest
    function automatic logic [16:0] sbc_sel_limit(input logic [2:0] sel);
        if (sel >= SBC_SEL_2P11 && sel <= SBC_SEL_2P16) begin
            sbc_sel_limit = sbc_thresh(int'(sel) - 1);
        end else begin
            sbc_sel_limit = SBC_T_2P16;
        end
    endfunction : sbc_sel_limit
endpackage : sbc_pkg

// File: design/sbc_settle_cnt.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// crystal stabilization counter
// ----------------------------------------
module sbc_settle_cnt import sbc_pkg::*; (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic crystal_clock,
    input wire logic osc_running,
    input wire logic clear,
    input wire logic [16:0] limit,
    output logic [SBC_FLAGS-1:0] flags,
    output logic done
);
    // crystal clock is sampled as an ordinary synchronous input
    logic fx_prev_r, fx_prev_nxt;
    logic [SBC_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [SBC_FLAGS-1:0] flag_r, flag_nxt;

    // count rising crystal edges once oscillating, saturating at limit
    always_comb begin
        fx_prev_nxt = crystal_clock;
        cnt_nxt = cnt_r;
        flag_nxt = flag_r;
        if (clear) begin
            cnt_nxt = '0;
            flag_nxt = '0;
        end else if (osc_running && crystal_clock && !fx_prev_r && cnt_r < limit) begin
            cnt_nxt = cnt_r + 17'h00001;
        end
        for (int i = 0; i < SBC_FLAGS; i++) begin
            // flags latch; bounded by limit so longer ones stay zero
            if (!clear && cnt_r >= sbc_thresh(i) && sbc_thresh(i) <= limit) begin
                flag_nxt[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            fx_prev_r <= 1'b0;
            cnt_r <= '0;
            flag_r <= '0;
        end else begin
            fx_prev_r <= fx_prev_nxt;
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign flags = flag_r;
    assign done = (cnt_r >= limit);

    never_past_limit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        cnt_r <= limit || $changed(limit)) else $error("counter passed limit");
    flags_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (flag_r[0] && !clear) |=> flag_r[0]) else $error("flag dropped");
endmodule : sbc_settle_cnt
`default_nettype wire

// File: design/sbc_wake_timer.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// down counter for wake and settle waits
// ----------------------------------------
module sbc_wake_timer import sbc_pkg::*; #(
    parameter int W = 16
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [W-1:0] count,
    output logic busy
);
    logic [W-1:0] cnt_r, cnt_nxt;

    // load wins over counting
    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = count;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign busy = (cnt_r != '0);
endmodule : sbc_wake_timer
`default_nettype wire

// File: sim/sbc_osc_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// crystal oscillator model
// ----------------------------------------
module sbc_osc_model #(
    parameter int START_DLY = 16
) (
    input wire logic sys_clk,
    input wire logic osc_on,
    output logic crystal_clock,
    output logic crystal_osc_pin
);
    int dly_r = 0;
    logic [1:0] div_r = 2'h0;

    // start-up delay, then a clock at a quarter of sys_clk; held low when off
    // so a stopped crystal never leaves a stale edge behind
    always @(posedge sys_clk) begin
        if (!osc_on) begin
            dly_r <= 0;
            div_r <= 2'h0;
        end else if (dly_r < START_DLY) begin
            dly_r <= dly_r + 1;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end

    // oscillation reported only once the start-up delay is over
    assign crystal_osc_pin = osc_on && (dly_r >= START_DLY);
    assign crystal_clock = div_r[1];
endmodule : sbc_osc_model
`default_nettype wire

// File: sim/test_standby_halt_osc_stabilization.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// standby block bench
// ----------------------------------------
module test_standby_halt_osc_stabilization import sbc_pkg::*;;
    logic sys_clk = 1'b0, sys_rst = 1'b1, hw_reset_req = 1'b0, pin_or_por_reset = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, reg_byte = 1'b1, halt_exec = 1'b0, stop_exec = 1'b0;
    logic crystal_osc_stop = 1'b0, cpu_on_crystal = 1'b0, ext_clock_mode = 1'b0, osc_on = 1'b0;
    logic irq_pending = 1'b0, irq_mask_flag = 1'b0, irq_priority_flag = 1'b0, irq_accept_enable = 1'b0;
    logic in_service_priority = 1'b0, wdt_osc_stoppable = 1'b0, main_stop_req = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [2:0] reg_bit = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic crystal_clock, crystal_osc_pin, cpu_clk_en, cpu_reset, vector_take, resume_next;
    logic main_clk_keep, wdt_clk_en, halted;
    int miscompares = 0, check_count = 0, n;

    // rows: write addr, write byte, write data, read addr, read byte, bit, expected
    logic [59:0] rows [10] = '{
        60'hffa4_1_01_ffa4_1_0_01, 60'hffa4_1_02_ffa4_1_0_02,
        60'hffa4_1_03_ffa4_1_0_03, 60'hffa4_1_04_ffa4_1_0_04,
        60'hffa4_1_05_ffa4_1_0_05, 60'hffa4_0_00_ffa4_1_0_05,
        60'hffa3_1_ff_ffa3_1_0_00, 60'h0000_0_00_ffa4_0_2_04,
        60'hffa4_1_ff_ffa4_1_0_07, 60'h0000_0_00_ffa5_1_0_00
    };

    always #25 sys_clk = ~sys_clk;

    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    sbc_standby #(.SETTLE_CYC(20)) sbc_standby_inst (
        .sys_clk, .sys_rst, .hw_reset_req, .pin_or_por_reset, .reg_addr, .reg_wr, .reg_rd,
        .reg_byte, .reg_bit, .reg_wdata, .reg_rdata, .halt_exec, .stop_exec, .crystal_osc_stop,
        .crystal_clock, .crystal_osc_pin, .cpu_on_crystal, .ext_clock_mode, .irq_pending,
        .irq_mask_flag, .irq_priority_flag, .irq_accept_enable, .in_service_priority,
        .wdt_osc_stoppable, .main_stop_req, .cpu_clk_en, .cpu_reset, .vector_take,
        .resume_next, .main_clk_keep, .wdt_clk_en, .halted
    );
    sbc_osc_model sbc_osc_model_inst (.sys_clk, .osc_on, .crystal_clock, .crystal_osc_pin);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // bounded wait for the cpu clock gate; cycles taken land in n
    task automatic wait_en(input logic v, input int lim);
        n = 0;
        while (cpu_clk_en !== v && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (cpu_clk_en !== v) begin
            miscompares++;
            final_report();
        end
    endtask : wait_en

    task automatic wr_reg(input logic [15:0] a, input logic b, input logic [2:0] bi, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_byte <= b;
        reg_bit <= bi;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr_reg

    // read data is registered, so it is looked at one cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic b, input logic [2:0] bi, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_byte <= b;
        reg_bit <= bi;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd_chk

    // halt, then release with flags f = mask, priority, accept, in-service
    task automatic hcase(input logic [3:0] f, input logic v);
        @(posedge sys_clk);
        {irq_mask_flag, irq_priority_flag, irq_accept_enable, in_service_priority} <= f;
        wdt_osc_stoppable <= v;
        halt_exec <= 1'b1;
        @(posedge sys_clk);
        halt_exec <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk(8'({halted, cpu_clk_en}), 8'h02);
        chk(8'({main_clk_keep, wdt_clk_en}), {6'h00, 1'b1, !v});
        @(posedge sys_clk);
        irq_pending <= 1'b1;
        n = 0;
        while (!(vector_take || resume_next) && n < 40) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk(8'({vector_take, resume_next}), {6'h00, v, !v});
        chk(8'(n >= (v ? 13 : 6) && n <= (v ? 15 : 8)), 8'h01);
        if (n >= 40) begin
            final_report();
        end
        @(posedge sys_clk);
        irq_pending <= 1'b0;
    endtask : hcase

    // stop with the crystal on the cpu; the oscillator restarts on the wake request
    task automatic scase(input logic [7:0] s, input logic [7:0] st, input int lo);
        wr_reg(SBC_ADDR_SELECT, 1'b1, 3'h0, s);
        @(posedge sys_clk);
        stop_exec <= 1'b1;
        osc_on <= 1'b0;
        @(posedge sys_clk);
        stop_exec <= 1'b0;
        rd_chk(SBC_ADDR_STATUS, 1'b1, 3'h0, 8'h00);
        @(posedge sys_clk);
        osc_on <= 1'b1;
        irq_pending <= 1'b1;
        wait_en(1'b1, lo + 2000);
        chk(8'(n >= lo), 8'h01);
        @(posedge sys_clk);
        irq_pending <= 1'b0;
        rd_chk(SBC_ADDR_STATUS, 1'b1, 3'h0, st);
    endtask : scase

    task automatic final_report();
        $display("comparisons %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wait_en(1'b1, 100);
        foreach (rows[i]) begin
            if (rows[i][59:44] != 16'h0000) begin
                wr_reg(rows[i][59:44], rows[i][40], rows[i][10:8], rows[i][39:32]);
            end
            rd_chk(rows[i][31:16], rows[i][12], rows[i][10:8], rows[i][7:0]);
        end
        hcase(4'b0000, 1'b0);
        hcase(4'b0010, 1'b1);
        hcase(4'b0101, 1'b0);
        hcase(4'b0110, 1'b0);
        hcase(4'b0111, 1'b1);
        // masked request must not wake; a pin reset then ends the halt
        @(posedge sys_clk);
        irq_mask_flag <= 1'b1;
        halt_exec <= 1'b1;
        @(posedge sys_clk);
        halt_exec <= 1'b0;
        irq_pending <= 1'b1;
        repeat (20) @(posedge sys_clk);
        #1;
        chk(8'(halted), 8'h01);
        @(posedge sys_clk);
        hw_reset_req <= 1'b1;
        pin_or_por_reset <= 1'b1;
        irq_pending <= 1'b0;
        irq_mask_flag <= 1'b0;
        repeat (2) @(posedge sys_clk);
        hw_reset_req <= 1'b0;
        #1;
        chk(8'({cpu_reset, halted}), 8'h02);
        wait_en(1'b1, 200);
        chk(8'(n >= 20), 8'h01);
        rd_chk(SBC_ADDR_SELECT, 1'b1, 3'h0, 8'h05);
        rd_chk(SBC_ADDR_STATUS, 1'b1, 3'h0, 8'h00);
        // short then longer selected waits, one crystal period is four cycles
        @(posedge sys_clk);
        cpu_on_crystal <= 1'b1;
        scase(8'h01, 8'h10, 8208);
        scase(8'h02, 8'h18, 32784);
        @(posedge sys_clk);
        crystal_osc_stop <= 1'b1;
        @(posedge sys_clk);
        crystal_osc_stop <= 1'b0;
        rd_chk(SBC_ADDR_STATUS, 1'b1, 3'h0, 8'h00);
        // fast internal clock: wake at once, software polls the status afterwards
        @(posedge sys_clk);
        cpu_on_crystal <= 1'b0;
        wr_reg(SBC_ADDR_SELECT, 1'b1, 3'h0, 8'h01);
        @(posedge sys_clk);
        stop_exec <= 1'b1;
        irq_pending <= 1'b1;
        @(posedge sys_clk);
        stop_exec <= 1'b0;
        wait_en(1'b1, 20);
        @(posedge sys_clk);
        irq_pending <= 1'b0;
        rd_chk(SBC_ADDR_STATUS, 1'b1, 3'h0, 8'h00);
        repeat (8300) @(posedge sys_clk);
        rd_chk(SBC_ADDR_STATUS, 1'b1, 3'h0, 8'h10);
        // external clock: reset must not wait on a crystal that never runs
        @(posedge sys_clk);
        cpu_on_crystal <= 1'b1;
        ext_clock_mode <= 1'b1;
        osc_on <= 1'b0;
        pin_or_por_reset <= 1'b0;
        hw_reset_req <= 1'b1;
        @(posedge sys_clk);
        hw_reset_req <= 1'b0;
        wait_en(1'b1, 10);
        final_report();
    end
endmodule : test_standby_halt_osc_stabilization
`default_nettype wire
